// *** dsrx_checker.sv ***
// Port assertions for the receive decode/track block
`timescale 1ns/1ps
`default_nettype none
module dsrx_checker #(
  parameter OFS_W = 8
) (
  // Clock, reset and bus
  input wire logic                    clk,
  input wire logic                    rst,
  input wire logic                    psel,
  input wire logic                    penable,
  input wire logic [11:0]             paddr,
  input wire logic                    pready,
  input wire logic                    pslverr,
  // Status and symbols
  input wire logic                    track_locked,
  input wire logic                    header_last,
  input wire logic                    packet_end,
  input wire logic                    sym_valid,
  input wire logic                    corr_valid,
  input wire logic                    corr_last,
  input wire logic                    el_valid,
  input wire logic                    el_late,
  // Outputs watched
  input wire logic signed [OFS_W-1:0] interp_offset,
  input wire logic                    timing_limit,
  input wire logic                    cck_active,
  input wire logic                    rx_bit_valid,
  input wire logic                    chip_valid
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_low_sym;
    sym_valid && track_locked && !cck_active;
  endsequence
  sequence s_cck_sym;
    corr_valid && corr_last && cck_active;
  endsequence
  ////////////////////////////////////////
  a_pready_zero_wait: assert property (pready == (psel && penable))
    else $error("pready not zero wait");
  a_unmapped_err: assert property (psel && !penable && paddr > 12'h018 |=> pslverr)
    else $error("no slave error on unmapped address");
  a_low_bit_lat: assert property (s_low_sym |-> ##2 rx_bit_valid)
    else $error("low rate bit late");
  a_cck_bit_run: assert property (s_cck_sym |-> ##2 rx_bit_valid [*4])
    else $error("short CCK bit run");
  a_cck_start_cause: assert property ($rose(cck_active) |-> $past(header_last && track_locked))
    else $error("CCK started without header");
  a_bit_cause: assert property ($rose(rx_bit_valid) |-> $past(sym_valid || corr_valid, 2))
    else $error("bit without symbol");
  a_packet_clear: assert property (packet_end |=> !cck_active && !timing_limit && interp_offset == 0)
    else $error("packet end did not clear");
  a_offset_range: assert property (interp_offset <= 72 && interp_offset >= -72)
    else $error("offset out of range");
  a_limit_set: assert property (el_valid && el_late && track_locked && !packet_end && interp_offset == 72
    |=> timing_limit && interp_offset == 72)
    else $error("limit not flagged");
  a_offset_step: assert property (el_valid && !el_late && track_locked && !packet_end && interp_offset > -72
    |=> interp_offset == $past(interp_offset) - 1)
    else $error("offset step wrong");
  a_chip_decim: assert property (chip_valid |=> !chip_valid)
    else $error("chip rate not decimated");
endmodule
`default_nettype wire

// *** dsrx_decode_track.v ***
// Receive decoding, CCK picking, equaliser and carrier/symbol tracking
//
// Notes on behaviour
// - Phase change 0/+90/+180/-90 gives 00/01/11/10
// - First bit of dibit leaves first
// - Rotation control bit 7 or 6 reverses
// - DBPSK is plain differential decoding
// - Descrambler is self-synchronising seven-stage register
// - Two taps XOR into incoming stream
// - Output is data XOR tap sum
// - CCK starts only after locked header
// - Last header bit phase is CCK reference
// - Derotate samples, then decimate to chip rate
// - 11 Mbps: six index bits, two phase
// - 5.5 Mbps: four correlators, four bits
// - Biggest picker once per symbol batch
// - Train on early samples, shared with CHANNEL_MATCHED_FILTER
// - Remove inter-chip term before picking
// - Subtract previous symbol residual from next
// - Coefficients frozen for rest of packet
// - Equaliser bits 4, 5 disable ICI, ISI
// - Costas error into lead/lag filter, NCO
// - Carrier integrator update only on chip transition
// - Interpolator limited to +/-72 eighth chips
// - Service bit 2 and receive bit 2
// - Tracking option bit 6 enables locked mode
//
// Design decisions made here: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "dsrx_regs.vh"

module dsrx_decode_track #(
  parameter SW    = 8,
  parameter MW    = 12,
  parameter OFS_W = 8
) (
  // Clock and reset
  input  wire                    clk,
  input  wire                    rst,
  // APB slave
  input  wire [11:0]             paddr,
  input  wire                    psel,
  input  wire                    penable,
  input  wire                    pwrite,
  input  wire [31:0]             pwdata,
  output reg  [31:0]             prdata,
  output wire                    pready,
  output reg                     pslverr,
  // Acquisition and header status
  input  wire                    track_locked,
  input  wire                    header_last,
  input  wire [7:0]              service_field,
  input  wire                    packet_end,
  // Low-rate symbol phases
  input  wire                    sym_valid,
  input  wire [1:0]              sym_phase,
  // Corrected A/D samples
  input  wire                    samp_valid,
  input  wire signed [SW-1:0]    samp_i,
  input  wire signed [SW-1:0]    samp_q,
  // Training samples
  input  wire                    train_valid,
  input  wire [MW-1:0]           train_mag,
  // Fast Walsh correlator results
  input  wire                    corr_valid,
  input  wire                    corr_last,
  input  wire [5:0]              corr_idx,
  input  wire [MW-1:0]           corr_mag,
  input  wire [1:0]              corr_phase,
  // Early/late chip decisions
  input  wire                    el_valid,
  input  wire                    el_late,
  // Chips toward correlators
  output reg                     chip_valid,
  output reg  signed [SW-1:0]    chip_i,
  output reg  signed [SW-1:0]    chip_q,
  // Tracking state
  output reg  [15:0]             nco_phase,
  output reg  signed [OFS_W-1:0] interp_offset,
  output reg                     timing_limit,
  output reg                     cck_active,
  output reg  [MW+3:0]           cmf_train_sum,
  // Bits toward MAC
  output wire                    rx_bit,
  output wire                    rx_bit_valid
);

  ////////////////////////////////////////////////////////////////////////
  // Functions

  function [2:0] reg_sel;
    input [11:0] a;
    begin
      case (a)
        {4'h0, `DSRX_OFS_ROT_CTRL}:  reg_sel = 3'h0;
        {4'h0, `DSRX_OFS_EQ_CTRL}:   reg_sel = 3'h1;
        {4'h0, `DSRX_OFS_LOCKED_RX}: reg_sel = 3'h2;
        {4'h0, `DSRX_OFS_TRACK_OPT}: reg_sel = 3'h3;
        {4'h0, `DSRX_OFS_RATE_CTRL}: reg_sel = 3'h4;
        {4'h0, `DSRX_OFS_EQ_COEF}:   reg_sel = 3'h5;
        {4'h0, `DSRX_OFS_STATUS}:    reg_sel = 3'h6;
        default:                     reg_sel = 3'h7;
      endcase
    end
  endfunction

  function [MW-1:0] sat_sub;
    input [MW-1:0] a;
    input [MW-1:0] b;
    begin
      sat_sub = (a > b) ? a - b : {MW{1'b0}};
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Registers

  reg [7:0]    rotation_control_reg;
  reg [7:0]    equalizer_control_reg;
  reg [7:0]    locked_clock_rx_reg;
  reg [7:0]    tracking_option_reg;
  reg [1:0]    rate_reg;
  reg [MW-1:0] eq_coef_reg;
  reg          eq_frozen_reg;
  reg          lo_mode_reg;
  reg [1:0]    phase_ref_reg;

  wire [2:0] sel      = reg_sel(paddr);
  wire       wr_en    = psel & penable & pwrite;
  wire       rev_rot  = rotation_control_reg[`DSRX_ROT_REV_A_BIT] |
                        rotation_control_reg[`DSRX_ROT_REV_B_BIT];
  wire       ici_dis  = equalizer_control_reg[`DSRX_EQ_ICI_DIS_BIT];
  wire       isi_dis  = equalizer_control_reg[`DSRX_EQ_ISI_DIS_BIT];

  assign pready = psel & penable;

  always @(posedge clk) begin
    if (rst) begin
      rotation_control_reg  <= `DSRX_ROT_CTRL_RST;
      equalizer_control_reg <= `DSRX_EQ_CTRL_RST;
      locked_clock_rx_reg   <= `DSRX_LOCKED_RX_RST;
      tracking_option_reg   <= `DSRX_TRACK_OPT_RST;
      rate_reg              <= `DSRX_RATE_CTRL_RST;
    end else if (wr_en) begin
      case (sel)
        3'h0:    rotation_control_reg  <= pwdata[7:0];
        3'h1:    equalizer_control_reg <= pwdata[7:0];
        3'h2:    locked_clock_rx_reg   <= pwdata[7:0];
        3'h3:    tracking_option_reg   <= pwdata[7:0];
        3'h4:    rate_reg              <= pwdata[1:0];
        default: rate_reg              <= rate_reg;
      endcase
    end
  end

  // Read data latched in the setup cycle
  always @(posedge clk) begin
    if (rst) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (psel & ~penable) begin
      pslverr <= (sel == 3'h7);
      case (sel)
        3'h0:    prdata <= {24'h00_0000, rotation_control_reg};
        3'h1:    prdata <= {24'h00_0000, equalizer_control_reg};
        3'h2:    prdata <= {24'h00_0000, locked_clock_rx_reg};
        3'h3:    prdata <= {24'h00_0000, tracking_option_reg};
        3'h4:    prdata <= {30'h0000_0000, rate_reg};
        3'h5:    prdata <= {{(32-MW){1'b0}}, eq_coef_reg};
        3'h6:    prdata <= {16'h0000, interp_offset[7:0], 1'b0, phase_ref_reg,
                            eq_frozen_reg, lo_mode_reg, cck_active, timing_limit,
                            track_locked};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Derotation, decimation and carrier loop

  reg signed [SW-1:0] rot_i;
  reg signed [SW-1:0] rot_q;
  reg                 rot_valid;
  reg                 dec_reg;
  reg signed [23:0]   integ_reg;
  reg                 prev_si;
  reg                 prev_sq;

  wire signed [SW+1:0] ci     = {{2{chip_i[SW-1]}}, chip_i};
  wire signed [SW+1:0] cq     = {{2{chip_q[SW-1]}}, chip_q};
  wire signed [SW+1:0] cos_err = (chip_i[SW-1] ? -cq : cq) - (chip_q[SW-1] ? -ci : ci);
  wire signed [23:0]   err24  = {{(24-SW-2){cos_err[SW+1]}}, cos_err};
  wire signed [23:0]   freq   = integ_reg + (err24 <<< `DSRX_KP_SHIFT);
  wire                 chip_trans = (chip_i[SW-1] != prev_si) | (chip_q[SW-1] != prev_sq);

  always @(posedge clk) begin
    if (rst) begin
      rot_i      <= {SW{1'b0}};
      rot_q      <= {SW{1'b0}};
      rot_valid  <= 1'b0;
      dec_reg    <= 1'b0;
      chip_valid <= 1'b0;
      chip_i     <= {SW{1'b0}};
      chip_q     <= {SW{1'b0}};
      nco_phase  <= 16'h0000;
      integ_reg  <= 24'sh00_0000;
      prev_si    <= 1'b0;
      prev_sq    <= 1'b0;
    end else begin
      rot_valid  <= samp_valid;
      chip_valid <= 1'b0;
      if (samp_valid) begin
        nco_phase <= nco_phase + freq[23:8];
        case (nco_phase[15:14])
          2'h0:    begin rot_i <= samp_i;  rot_q <= samp_q;  end
          2'h1:    begin rot_i <= samp_q;  rot_q <= -samp_i; end
          2'h2:    begin rot_i <= -samp_i; rot_q <= -samp_q; end
          default: begin rot_i <= -samp_q; rot_q <= samp_i;  end
        endcase
      end
      if (rot_valid) begin
        dec_reg <= ~dec_reg;
        if (dec_reg) begin
          chip_valid <= 1'b1;
          chip_i     <= rot_i;
          chip_q     <= rot_q;
        end
      end
      if (chip_valid) begin
        prev_si <= chip_i[SW-1];
        prev_sq <= chip_q[SW-1];
        if (track_locked && chip_trans) begin
          integ_reg <= integ_reg + (err24 <<< `DSRX_KI_SHIFT);
        end
      end
      if (packet_end) begin
        integ_reg <= 24'sh00_0000;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Symbol timing interpolator

  reg signed [15:0] lo_acc;
  wire signed [15:0] lo_sum = lo_acc + freq[23:8];
  reg step_fwd;
  reg step_bwd;
  reg signed [15:0] lo_next;

  always @* begin
    step_fwd = 1'b0;
    step_bwd = 1'b0;
    lo_next  = lo_acc;
    if (lo_mode_reg) begin
      if (chip_valid) begin
        if (lo_sum >= `DSRX_LO_STEP_THR) begin
          step_fwd = 1'b1;
          lo_next  = lo_sum - `DSRX_LO_STEP_THR;
        end else if (lo_sum <= -`DSRX_LO_STEP_THR) begin
          step_bwd = 1'b1;
          lo_next  = lo_sum + `DSRX_LO_STEP_THR;
        end else begin
          lo_next = lo_sum;
        end
      end
    end else begin
      step_fwd = el_valid & el_late;
      step_bwd = el_valid & ~el_late;
    end
  end

  always @(posedge clk) begin
    if (rst || packet_end) begin
      interp_offset <= {OFS_W{1'b0}};
      timing_limit  <= 1'b0;
      lo_acc        <= 16'sh0000;
    end else begin
      lo_acc <= lo_next;
      if (step_fwd) begin
        if (interp_offset < $signed(`DSRX_INTERP_LIMIT)) begin
          interp_offset <= interp_offset + 1'b1;
        end else begin
          timing_limit <= 1'b1;
        end
      end else if (step_bwd) begin
        if (interp_offset > -$signed(`DSRX_INTERP_LIMIT)) begin
          interp_offset <= interp_offset - 1'b1;
        end else begin
          timing_limit <= 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Equaliser training and header handover

  reg train_d;

  always @(posedge clk) begin
    if (rst) begin
      cmf_train_sum <= {(MW+4){1'b0}};
      eq_coef_reg   <= {MW{1'b0}};
      eq_frozen_reg <= 1'b0;
      train_d       <= 1'b0;
      cck_active    <= 1'b0;
      lo_mode_reg   <= 1'b0;
      phase_ref_reg <= 2'h0;
    end else begin
      train_d <= train_valid & ~eq_frozen_reg;
      // Same samples feed CHANNEL_MATCHED_FILTER and equaliser
      if (train_valid && !eq_frozen_reg) begin
        cmf_train_sum <= cmf_train_sum + {4'h0, train_mag};
      end
      if (train_d && !train_valid) begin
        eq_coef_reg   <= cmf_train_sum[MW+3:`DSRX_TRAIN_SHIFT];
        eq_frozen_reg <= 1'b1;
      end
      // Hand over at last header bit
      if (header_last && track_locked) begin
        phase_ref_reg <= sym_phase;
        cck_active    <= rate_reg[1];
        lo_mode_reg   <= tracking_option_reg[`DSRX_TRACK_LO_EN_BIT] &
                         locked_clock_rx_reg[`DSRX_LOCKED_RX_BIT] &
                         service_field[`DSRX_SERVICE_LOCK_BIT];
      end
      if (packet_end) begin
        cck_active    <= 1'b0;
        lo_mode_reg   <= 1'b0;
        eq_frozen_reg <= 1'b0;
        cmf_train_sum <= {(MW+4){1'b0}};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // CCK biggest picker

  reg [MW-1:0] best_mag;
  reg [5:0]    best_idx;
  reg [1:0]    best_phase;
  reg          best_valid;
  reg [MW-1:0] isi_term;
  reg [1:0]    cck_prev;

  // Only four candidates at 5.5 Mbps
  wire          eligible = (rate_reg == `DSRX_RATE_CCK11) || (corr_idx < `DSRX_CCK55_CORRS);
  wire [MW-1:0] mag_ici  = ici_dis ? corr_mag
                                   : sat_sub(corr_mag, eq_coef_reg >> `DSRX_ICI_SHIFT);
  wire [MW-1:0] mag_adj  = isi_dis ? mag_ici : sat_sub(mag_ici, isi_term);
  wire          take     = eligible & (~best_valid | (mag_adj > best_mag));
  wire [MW-1:0] fin_mag  = take ? mag_adj : best_mag;
  wire [5:0]    fin_idx  = take ? corr_idx : best_idx;
  wire [1:0]    fin_ph   = take ? corr_phase : best_phase;
  wire [2*MW-1:0] resid  = fin_mag * eq_coef_reg;
  wire          cck_dec  = cck_active & corr_valid & corr_last;

  always @(posedge clk) begin
    if (rst) begin
      best_mag   <= {MW{1'b0}};
      best_idx   <= 6'h00;
      best_phase <= 2'h0;
      best_valid <= 1'b0;
      isi_term   <= {MW{1'b0}};
      cck_prev   <= 2'h0;
    end else if (packet_end) begin
      best_valid <= 1'b0;
      isi_term   <= {MW{1'b0}};
    end else if (header_last && track_locked) begin
      cck_prev <= sym_phase;
    end else if (cck_active && corr_valid) begin
      if (corr_last) begin
        best_valid <= 1'b0;
        isi_term   <= resid[2*MW-1:MW];
        cck_prev   <= fin_ph;
      end else if (take) begin
        best_valid <= 1'b1;
        best_mag   <= mag_adj;
        best_idx   <= corr_idx;
        best_phase <= corr_phase;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Differential decoding and serialiser

  reg  [1:0] prev_phase;
  reg  [7:0] ser_reg;
  reg  [3:0] ser_cnt;
  wire [1:0] dibit;

  dsrx_diff_decoder u_diff (
    .cur_phase  (cck_active ? fin_ph : sym_phase),
    .prev_phase (cck_active ? cck_prev : prev_phase),
    .reverse    (rev_rot),
    .dibit      (dibit)
  );

  always @(posedge clk) begin
    if (rst) begin
      prev_phase <= 2'h0;
      ser_reg    <= 8'h00;
      ser_cnt    <= 4'h0;
    end else begin
      if (ser_cnt != 4'h0) begin
        ser_reg <= {ser_reg[6:0], 1'b0};
        ser_cnt <= ser_cnt - 4'h1;
      end
      if (sym_valid) begin
        prev_phase <= sym_phase;
      end
      if (cck_dec) begin
        if (rate_reg == `DSRX_RATE_CCK11) begin
          ser_reg <= {dibit, fin_idx};
          ser_cnt <= 4'h8;
        end else begin
          ser_reg <= {dibit, fin_idx[1:0], 4'h0};
          ser_cnt <= 4'h4;
        end
      end else if (sym_valid && track_locked && !cck_active) begin
        if (rate_reg == `DSRX_RATE_DQPSK) begin
          ser_reg <= {dibit, 6'h00};
          ser_cnt <= 4'h2;
        end else begin
          ser_reg <= {dibit[1], 7'h00};
          ser_cnt <= 4'h1;
        end
      end
    end
  end

  dsrx_descrambler u_descr (
    .clk       (clk),
    .rst       (rst),
    .in_valid  (ser_cnt != 4'h0),
    .in_bit    (ser_reg[7]),
    .out_valid (rx_bit_valid),
    .out_bit   (rx_bit)
  );

endmodule

`default_nettype wire

// *** dsrx_descrambler.v ***
// Self-synchronising seven-stage descrambler
`timescale 1ns/1ps
`default_nettype none

module dsrx_descrambler (
  // Clock and reset
  input  wire clk,
  input  wire rst,
  // Scrambled bit in
  input  wire in_valid,
  input  wire in_bit,
  // Descrambled bit out
  output reg  out_valid,
  output reg  out_bit
);

  reg [6:0] shift_reg;

  always @(posedge clk) begin
    if (rst) begin
      shift_reg <= 7'h00;
      out_valid <= 1'b0;
      out_bit   <= 1'b0;
    end else begin
      out_valid <= in_valid;
      if (in_valid) begin
        shift_reg <= {shift_reg[5:0], in_bit};
        out_bit   <= in_bit ^ shift_reg[3] ^ shift_reg[6];
      end
    end
  end

endmodule

`default_nettype wire

// *** dsrx_diff_decoder.v ***
// Differential phase decoder for DBPSK, DQPSK and CCK phase bits
`timescale 1ns/1ps
`default_nettype none

module dsrx_diff_decoder (
  // Phases in quarter turns
  input  wire [1:0] cur_phase,
  input  wire [1:0] prev_phase,
  input  wire       reverse,
  // Decoded dibit, d0 in bit 1
  output reg  [1:0] dibit
);

  reg [1:0] delta;

  always @* begin
    delta = cur_phase - prev_phase;
    if (reverse) begin
      delta = 2'h0 - delta;
    end
    case (delta)
      2'h0:    dibit = 2'b00;
      2'h1:    dibit = 2'b01;
      2'h2:    dibit = 2'b11;
      default: dibit = 2'b10;
    endcase
  end

endmodule

`default_nettype wire

// *** dsrx_mac_sink.sv ***
// Bit sink standing for the MAC receive side
`timescale 1ns/1ps
`default_nettype none
module dsrx_mac_sink (
  // Clock and bit stream
  input wire logic clk,
  input wire logic rx_bit,
  input wire logic rx_bit_valid
);
  logic bits[$];
  always @(posedge clk) begin
    if (rx_bit_valid === 1'b1) begin
      bits.push_back(rx_bit);
    end
  end
endmodule
`default_nettype wire

// *** dsrx_regs.vh ***
// Register map, field positions, reset values and counts of the receive decode/track block
`ifndef DSRX_REGS_VH
`define DSRX_REGS_VH

// Register byte offsets
`define DSRX_OFS_ROT_CTRL     8'h00
`define DSRX_OFS_EQ_CTRL      8'h04
`define DSRX_OFS_LOCKED_RX    8'h08
`define DSRX_OFS_TRACK_OPT    8'h0c
`define DSRX_OFS_RATE_CTRL    8'h10
`define DSRX_OFS_EQ_COEF      8'h14
`define DSRX_OFS_STATUS       8'h18

// Field positions
`define DSRX_ROT_REV_A_BIT    7
`define DSRX_ROT_REV_B_BIT    6
`define DSRX_EQ_ICI_DIS_BIT   4
`define DSRX_EQ_ISI_DIS_BIT   5
`define DSRX_LOCKED_RX_BIT    2
`define DSRX_SERVICE_LOCK_BIT 2
`define DSRX_TRACK_LO_EN_BIT  6

// Reset values
`define DSRX_ROT_CTRL_RST     8'h00
`define DSRX_EQ_CTRL_RST      8'h00
`define DSRX_LOCKED_RX_RST    8'h00
`define DSRX_TRACK_OPT_RST    8'h00
`define DSRX_RATE_CTRL_RST    2'h0

// Rate modes
`define DSRX_RATE_DBPSK       2'h0
`define DSRX_RATE_DQPSK       2'h1
`define DSRX_RATE_CCK55       2'h2
`define DSRX_RATE_CCK11       2'h3

// Counts and loop shifts
`define DSRX_INTERP_LIMIT     8'd72
`define DSRX_CCK55_CORRS      6'd4
`define DSRX_KI_SHIFT         4
`define DSRX_KP_SHIFT         8
`define DSRX_TRAIN_SHIFT      4
`define DSRX_ICI_SHIFT        2
`define DSRX_LO_STEP_THR      16'sd4096

`endif

// *** dsrx_tb.sv ***
// Self-checking bench of the receive decode/track block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic               clk = 1'b0;
  logic               rst = 1'b1;
  logic [11:0]        paddr = 12'h000;
  logic               psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [31:0]        pwdata = 32'h0, prdata, seed = 32'hd8c2, sseed = 32'hd8c2;
  logic               pready, pslverr, chip_valid, timing_limit, cck_active;
  logic               rx_bit, rx_bit_valid, first;
  logic signed [7:0]  samp_i = 8'h00, samp_q = 8'h00, chip_i, chip_q, interp_offset;
  logic [15:0]        nco_phase, cmf_train_sum;
  logic               track_locked = 1'b1, header_last = 1'b0, packet_end = 1'b0;
  logic               sym_valid = 1'b0, samp_valid = 1'b0, train_valid = 1'b0;
  logic               corr_valid = 1'b0, corr_last = 1'b0, el_valid = 1'b0, el_late = 1'b0;
  logic [7:0]         service_field = 8'h00;
  logic [1:0]         sym_phase = 2'h0, corr_phase = 2'h0, wph, lph = 2'h0;
  logic [5:0]         corr_idx = 6'h00, widx;
  logic [11:0]        train_mag = 12'h000, corr_mag = 12'h000, wmag;
  logic               din[$];
  int                 failures = 0, samples_checked = 0, cycles = 0;

  dsrx_decode_track i_dut (.*);
  dsrx_mac_sink i_mac (.*);
  always #5 clk = ~clk;
  always @(posedge clk) begin
    sseed <= lfsr(sseed);
    samp_valid <= ~samp_valid & ~rst;
    samp_i <= sseed[7:0];
    samp_q <= sseed[15:8];
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      failures++;
      finish_test();
    end
  end
  ////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [1:0] dq(input logic [1:0] d);
    return {d[1], d[1] ^ d[0]};
  endfunction
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d,
                     input logic [31:0] m, input logic [31:0] exp, input logic err);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    check("read data", prdata & m, exp);
    check("slave error", {31'h0, pslverr}, {31'h0, err});
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic put(input logic [7:0] v, input int n);
    for (int i = n - 1; i >= 0; i--) din.push_back(v[i]);
  endtask
  task automatic expect_bits;
    repeat (12) @(posedge clk);
    check("bit count", i_mac.bits.size(), din.size());
    for (int i = 7; i < din.size(); i++)
      check("rx bit", {31'h0, i_mac.bits[i]}, {31'h0, din[i] ^ din[i-4] ^ din[i-7]});
    din.delete();
    i_mac.bits.delete();
  endtask
  task automatic sym(input logic [1:0] ph, input logic last);
    @(posedge clk);
    sym_valid <= 1'b1;
    sym_phase <= ph;
    header_last <= last;
    @(posedge clk);
    sym_valid <= 1'b0;
    header_last <= 1'b0;
    repeat (10) @(posedge clk);
  endtask
  task automatic pulse_end;
    @(posedge clk);
    packet_end <= 1'b1;
    @(posedge clk);
    packet_end <= 1'b0;
    @(posedge clk);
  endtask
  ////////////////////////////////////////
  task automatic low_test(input logic [1:0] rate, input logic [31:0] rot);
    logic [1:0] prev, ph, d;
    apb(12'h000, 1'b1, rot, 0, 0, 1'b0);
    apb(12'h010, 1'b1, {30'h0, rate}, 0, 0, 1'b0);
    prev = lph;
    for (int k = 0; k < 20; k++) begin
      seed = lfsr(seed);
      ph = (k < 4) ? prev + (rate[0] ? k[1:0] : 2'h2) : (rate[0] ? seed[1:0] : {seed[1], 1'b0});
      d = (rot != 0) ? prev - ph : ph - prev;
      if (rate[0]) put({6'h0, dq(d)}, 2);
      else put({7'h0, d[1]}, 1);
      sym(ph, 1'b0);
      prev = ph;
    end
    lph = prev;
    expect_bits();
    $display("low rate test %0d rot %h done", rate, rot);
  endtask
  task automatic corr(input logic [5:0] i, input logic [11:0] m, input logic [1:0] p,
                      input logic last, input logic cand);
    @(posedge clk);
    corr_valid <= 1'b1;
    corr_idx <= i;
    corr_mag <= m;
    corr_phase <= p;
    corr_last <= last;
    if (cand && (first || m > wmag)) begin
      wmag = m;
      widx = i;
      wph = p;
      first = 1'b0;
    end
    if (last) begin
      @(posedge clk);
      corr_valid <= 1'b0;
      corr_last <= 1'b0;
    end
  endtask
  task automatic cck_test(input logic [1:0] rate, input logic lo);
    logic [1:0] prev;
    apb(12'h00c, 1'b1, {25'h0, lo, 6'h0}, 0, 0, 1'b0);
    apb(12'h010, 1'b1, {30'h0, rate}, 0, 0, 1'b0);
    seed = lfsr(seed);
    prev = seed[1:0];
    service_field <= {seed[15:11], 1'b1, seed[9:8]};
    sym(prev, 1'b1);
    din.delete();
    i_mac.bits.delete();
    apb(12'h018, 1'b0, 0, 32'h7c, {25'h0, prev, 1'b1, lo, 1'b1, 2'h0}, 1'b0);
    for (int s = 0; s < 6; s++) begin
      first = 1'b1;
      if (!rate[0]) corr(6'h3f, 12'hfff, 2'h0, 1'b0, 1'b0);
      for (int j = 0; j < 4; j++) begin
        seed = lfsr(seed);
        corr(rate[0] ? seed[5:0] : {4'h0, seed[1:0]}, seed[19:8], seed[21:20], j == 3, 1'b1);
      end
      put({6'h0, dq(wph - prev)}, 2);
      put({2'h0, widx}, rate[0] ? 6 : 2);
      prev = wph;
      repeat (12) @(posedge clk);
    end
    expect_bits();
    $display("cck test rate %0d done", rate);
  endtask
  task automatic el_test(input logic late, input logic [7:0] lim);
    repeat (75) begin
      @(posedge clk);
      el_valid <= 1'b1;
      el_late <= late;
    end
    @(posedge clk);
    el_valid <= 1'b0;
    @(posedge clk);
    check("offset", {24'h0, interp_offset}, {24'h0, lim});
    check("limit", {31'h0, timing_limit}, 32'h1);
    pulse_end();
    check("offset cleared", {24'h0, interp_offset}, 32'h0);
    $display("timing test %0d done", late);
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    for (int a = 0; a < 20; a += 4) apb(a[11:0], 1'b0, 0, 32'hffffffff, 0, 1'b0);
    for (int a = 0; a < 20; a += 4) apb(a[11:0], 1'b1, 32'hff, 0, 0, 1'b0);
    for (int a = 0; a < 20; a += 4)
      apb(a[11:0], 1'b0, 0, 32'hffffffff, (a == 16) ? 32'h3 : 32'hff, 1'b0);
    apb(12'h014, 1'b1, 32'hfff, 0, 0, 1'b0);
    apb(12'h014, 1'b0, 0, 32'hffffffff, 0, 1'b0);
    apb(12'h040, 1'b0, 0, 0, 0, 1'b1);
    for (int a = 0; a < 20; a += 4) apb(a[11:0], 1'b1, (a == 8) ? 32'h4 : 32'h0, 0, 0, 1'b0);
    $display("register test done");
    for (int t = 0; t < 2; t++) begin
      @(posedge clk);
      train_valid <= 1'b1;
      train_mag <= 12'h004;
      repeat (3) @(posedge clk);
      train_valid <= 1'b0;
      repeat (2) @(posedge clk);
      check("train sum", {16'h0, cmf_train_sum}, 32'hc);
    end
    $display("training test done");
    low_test(2'h0, 32'h0);
    low_test(2'h1, 32'h80);
    low_test(2'h1, 32'h40);
    low_test(2'h0, 32'h80);
    low_test(2'h1, 32'h0);
    apb(12'h004, 1'b1, 32'h30, 0, 0, 1'b0);
    cck_test(2'h3, 1'b1);
    cck_test(2'h2, 1'b0);
    pulse_end();
    track_locked <= 1'b0;
    sym(2'h1, 1'b1);
    check("cck gated", {31'h0, cck_active}, 32'h0);
    track_locked <= 1'b1;
    el_test(1'b1, 8'h48);
    el_test(1'b0, 8'hb8);
    finish_test();
  end
endmodule
bind dsrx_decode_track dsrx_checker #(.OFS_W(OFS_W)) i_chk (.*);
`default_nettype wire
